// >>> rtl/bic_consts.vh
`ifndef BIC_CONSTS_VH
`define BIC_CONSTS_VH

// Register map, byte addresses
`define BIC_ADDR_W        8
`define BIC_REG_BCC       8'h00

// Field positions in bus_common_control
`define BIC_POS_CNT_HI    7
`define BIC_POS_CNT_LO    6
`define BIC_POS_MODE      5
`define BIC_POS_RSV1      4
`define BIC_POS_RSV0_HI   3
`define BIC_POS_RSV0_LO   2
`define BIC_POS_DRIVE     1

// Reset and fixed read values
`define BIC_RST_MODE      1'h0
`define BIC_RST_DRIVE     1'h0
`define BIC_RST_CNT       2'h0
`define BIC_RSV1_VAL      1'h1
`define BIC_RSV0_VAL      2'h0
`define BIC_ZERO32        32'h0000_0000

// Idle placement encodings
`define BIC_MODE_HANDOVER 1'h0
`define BIC_MODE_ALWAYS   1'h1

// Idle count field is two bits wide
`define BIC_CNT_ZERO      2'h0
`define BIC_CNT_ONE       2'h1
`define BIC_CNT_MAX       2'h3

`endif

// >>> rtl/bic_idle_gen.v
`timescale 1ns/1ps
`include "bic_consts.vh"

// Decides how many idle cycles must precede the next access
module bic_idle_gen (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rstn,
    // Configuration
    input  wire       mode,
    input  wire [1:0] idle_count,
    // Bus sequencer status
    input  wire       acc_end,
    input  wire       bus_busy,
    input  wire       end_dma_transfer_ack_pin,
    input  wire       end_dma_transfer_ack_pin_drv,
    // Candidate next access
    input  wire       nxt_dma_transfer_ack_pin,
    input  wire       nxt_dma_transfer_ack_pin_drv,
    output reg  [1:0] need
);

    reg       last_valid;   // An access has happened since reset
    reg       last_dma_transfer_ack_pin;    // Last access was to acknowledged device
    reg       last_drv;     // Acknowledged device drove data last
    reg [1:0] elapsed;      // Quiet cycles since last access, saturating
    reg       gap_wanted;   // Placement condition met

    // Remember the data bus owner of the previous access
    always @(posedge ref_clk) begin
        if (!rstn) begin
            last_valid <= 1'b0;
            last_dma_transfer_ack_pin  <= 1'b0;
            last_drv   <= 1'b0;
            elapsed    <= `BIC_CNT_ZERO;
        end else if (acc_end) begin
            last_valid <= 1'b1;
            last_dma_transfer_ack_pin  <= end_dma_transfer_ack_pin;
            last_drv   <= end_dma_transfer_ack_pin_drv;
            elapsed    <= `BIC_CNT_ZERO;
        end else if (!bus_busy && elapsed != `BIC_CNT_MAX) begin
            // Bus already quiet counts toward the idle demand
            elapsed <= elapsed + `BIC_CNT_ONE;
        end
    end

    // Placement from mode, length from the count field
    always @* begin
        gap_wanted = 1'b0;
        need       = `BIC_CNT_ZERO;
        if (last_valid) begin
            if (mode == `BIC_MODE_ALWAYS) begin
                // After every access to the acknowledged device
                gap_wanted = last_dma_transfer_ack_pin;
            end else begin
                // Only on a hand-over of the data bus
                // Same driver again needs no gap
                // Drive flag counts only for an acknowledged access
                gap_wanted = last_drv & ~(nxt_dma_transfer_ack_pin & nxt_dma_transfer_ack_pin_drv);
            end
        end
        // Quiet cycles already spent reduce the remainder
        if (gap_wanted && idle_count > elapsed)
            need = idle_count - elapsed;
    end

endmodule

// >>> rtl/bic_top.v
// Notes on behaviour
// - Mode picks placement; two-bit field gives count
// - Mode 0: idle when data bus changes driver
// - Mode 0: no idle for same driver
// - Mode 1: idle after every acknowledged access
// - Mode bit 5 resets 0, read/write
// - Bit 4 reads 1; software writes 1
// - Bits 3,2 read 0; software writes 0
// - Drive bit 0: pins float in standby
// - Drive bit 1: pins driven in standby
// - Bus released: pins float regardless
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "bic_consts.vh"

module bic_top #(
    parameter AREAS      = 8,   // Number of area select pins
    parameter AREA_W     = 3,   // Width of an area number
    parameter ACC_CYCLES = 2    // Bus cycles per access
) (
    // Clock and reset
    input  wire                   ref_clk,
    input  wire                   rstn,
    // Register port
    input  wire [`BIC_ADDR_W-1:0] reg_addr,
    input  wire [31:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [31:0]            reg_rdata,
    // System state
    input  wire                   sw_standby,
    input  wire                   bus_release,
    // Access request side
    input  wire                   acc_req,
    input  wire [29:0]            acc_addr,
    input  wire                   acc_write,
    input  wire [3:0]             acc_be,
    input  wire [AREA_W-1:0]      acc_area,
    input  wire                   acc_card,
    input  wire                   acc_dma_transfer_ack_pin,
    input  wire                   acc_dma_transfer_ack_pin_drv,
    output reg                    acc_ready,
    output reg                    acc_done,
    // Address pins
    output reg  [29:0]            addr_pins,
    output reg                    addr_oe,
    // Control and strobe pins, all sharing ctrl_oe
    output reg                    bus_cycle_start_pin_n,
    output reg  [AREAS-1:0]       area_select_pins_n,
    output reg                    read_write_dir_pin,
    output reg  [3:0]             byte_write_strobes_n,
    output reg                    rd_strobe_pin_n,
    output reg                    addr_hold_pin,
    output reg                    frame_pin_n,
    output reg                    card_io_read_pin_n,
    output reg                    card_io_write_pin_n,
    output reg                    we_pin_n,
    output reg                    card_a_enable_low_n,
    output reg                    card_b_enable_low_n,
    output reg                    card_a_enable_high_n,
    output reg                    card_b_enable_high_n,
    output reg                    ctrl_oe,
    // Acknowledge pin, never floated
    output reg                    dma_transfer_ack_pin
);

    // Sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_GAP  = 2'h1;
    localparam ST_ACC  = 2'h2;

    // Access length counter limit, cut to the counter width on purpose
    localparam integer ACC_LAST_I = ACC_CYCLES - 1;
    localparam [3:0]   ACC_LAST   = ACC_LAST_I[3:0];

    // Register fields
    reg        dma_idle_placement_mode;  // Idle placement select
    reg        dma_idle_count_hi;        // Idle count, upper bit
    reg        dma_idle_count_lo;        // Idle count, lower bit
    reg        standby_pin_drive_sel;    // Drive pins in standby
    wire [1:0] idle_count;               // Joined idle count
    wire [31:0] bcc_value;               // Register read image

    // Sequencer state
    reg [1:0]        state;     // Current sequencer state
    reg [1:0]        gap_cnt;   // Idle cycles still to run
    reg [3:0]        acc_cnt;   // Cycle within access
    wire [1:0]       need;      // Idle demand for next access
    wire             acc_take;  // Request accepted this cycle
    wire             acc_end;   // Last cycle of an access

    // Latched request
    reg [29:0]       cur_addr;
    reg              cur_write;
    reg [3:0]        cur_be;
    reg [AREA_W-1:0] cur_area;
    reg              cur_card;
    reg              cur_dma_transfer_ack_pin;
    reg              cur_dma_transfer_ack_pin_drv;

    // Source of the access about to start
    wire [29:0]       sel_addr;
    wire              sel_write;
    wire [3:0]        sel_be;
    wire [AREA_W-1:0] sel_area;
    wire              sel_card;
    wire              sel_dma_transfer_ack_pin;
    wire              sel_pins_drv;   // Pins may be driven

    assign idle_count = {dma_idle_count_hi, dma_idle_count_lo};
    assign acc_take   = acc_req & acc_ready & (state == ST_IDLE);
    assign acc_end    = (state == ST_ACC) & (acc_cnt == ACC_LAST);

    // From the inputs when leaving idle, else from the latch
    assign sel_addr  = (state == ST_IDLE) ? acc_addr  : cur_addr;
    assign sel_write = (state == ST_IDLE) ? acc_write : cur_write;
    assign sel_be    = (state == ST_IDLE) ? acc_be    : cur_be;
    assign sel_area  = (state == ST_IDLE) ? acc_area  : cur_area;
    assign sel_card  = (state == ST_IDLE) ? acc_card  : cur_card;
    assign sel_dma_transfer_ack_pin  = (state == ST_IDLE) ? acc_dma_transfer_ack_pin  : cur_dma_transfer_ack_pin;

    // Release wins over the drive select
    // Standby floats pins unless drive select is set
    assign sel_pins_drv = ~bus_release &
                          (~sw_standby | standby_pin_drive_sel);

    // Read image; reserved bits tied to their fixed values
    assign bcc_value = {24'h00_0000,
                        dma_idle_count_hi,
                        dma_idle_count_lo,
                        dma_idle_placement_mode,
                        `BIC_RSV1_VAL,
                        `BIC_RSV0_VAL,
                        standby_pin_drive_sel,
                        1'b0};

    // Register writes; reserved positions ignore written data
    always @(posedge ref_clk) begin
        if (!rstn) begin
            dma_idle_placement_mode <= `BIC_RST_MODE;
            standby_pin_drive_sel   <= `BIC_RST_DRIVE;
            dma_idle_count_hi       <= 1'b0;
            dma_idle_count_lo       <= 1'b0;
        end else if (reg_wr && reg_addr == `BIC_REG_BCC) begin
            dma_idle_placement_mode <= reg_wdata[`BIC_POS_MODE];
            standby_pin_drive_sel   <= reg_wdata[`BIC_POS_DRIVE];
            dma_idle_count_hi       <= reg_wdata[`BIC_POS_CNT_HI];
            dma_idle_count_lo       <= reg_wdata[`BIC_POS_CNT_LO];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata <= `BIC_ZERO32;
        end else if (reg_rd && reg_addr == `BIC_REG_BCC) begin
            reg_rdata <= bcc_value;
        end else begin
            // Unmapped address or no read reads as zero
            reg_rdata <= `BIC_ZERO32;
        end
    end

    // Idle demand from the previous bus owner
    bic_idle_gen u_idle (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .mode         (dma_idle_placement_mode),
        .idle_count   (idle_count),
        .acc_end      (acc_end),
        .bus_busy     (state != ST_IDLE),
        .end_dma_transfer_ack_pin     (cur_dma_transfer_ack_pin),
        .end_dma_transfer_ack_pin_drv (cur_dma_transfer_ack_pin_drv),
        .nxt_dma_transfer_ack_pin     (acc_dma_transfer_ack_pin),
        .nxt_dma_transfer_ack_pin_drv (acc_dma_transfer_ack_pin & acc_dma_transfer_ack_pin_drv),
        .need         (need)
    );

    // Latch an accepted request
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cur_addr     <= 30'h0000_0000;
            cur_write    <= 1'b0;
            cur_be       <= 4'h0;
            cur_area     <= {AREA_W{1'b0}};
            cur_card     <= 1'b0;
            cur_dma_transfer_ack_pin     <= 1'b0;
            cur_dma_transfer_ack_pin_drv <= 1'b0;
        end else if (acc_take) begin
            cur_addr     <= acc_addr;
            cur_write    <= acc_write;
            cur_be       <= acc_be;
            cur_area     <= acc_area;
            cur_card     <= acc_card;
            cur_dma_transfer_ack_pin     <= acc_dma_transfer_ack_pin;
            // Only an acknowledged access can hand over the bus
            cur_dma_transfer_ack_pin_drv <= acc_dma_transfer_ack_pin & acc_dma_transfer_ack_pin_drv;
        end
    end

    // Sequencer: optional idle gap, then a fixed access
    always @(posedge ref_clk) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            gap_cnt   <= `BIC_CNT_ZERO;
            acc_cnt   <= 4'h0;
            acc_ready <= 1'b1;
            acc_done  <= 1'b0;
        end else begin
            acc_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (acc_take) begin
                        acc_ready <= 1'b0;
                        acc_cnt   <= 4'h0;
                        if (need != `BIC_CNT_ZERO) begin
                            // Gap placed by mode, sized by field
                            state   <= ST_GAP;
                            gap_cnt <= need;
                        end else begin
                            state <= ST_ACC;
                        end
                    end
                end
                ST_GAP: begin
                    // Bus stays quiet for the idle cycles
                    if (gap_cnt == `BIC_CNT_ONE) begin
                        state <= ST_ACC;
                    end else begin
                        gap_cnt <= gap_cnt - `BIC_CNT_ONE;
                    end
                end
                ST_ACC: begin
                    if (acc_cnt == ACC_LAST) begin
                        state     <= ST_IDLE;
                        acc_ready <= 1'b1;
                        acc_done  <= 1'b1;
                    end else begin
                        acc_cnt <= acc_cnt + 4'h1;
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    acc_ready <= 1'b1;
                end
            endcase
        end
    end

    // An access starts on this edge
    wire acc_start;
    assign acc_start = (state == ST_IDLE && acc_take &&
                        need == `BIC_CNT_ZERO) ||
                       (state == ST_GAP && gap_cnt == `BIC_CNT_ONE);

    // Strobe pins; inactive levels between accesses
    always @(posedge ref_clk) begin
        if (!rstn) begin
            addr_pins             <= 30'h0000_0000;
            bus_cycle_start_pin_n <= 1'b1;
            area_select_pins_n    <= {AREAS{1'b1}};
            read_write_dir_pin    <= 1'b1;
            byte_write_strobes_n  <= 4'hf;
            rd_strobe_pin_n       <= 1'b1;
            addr_hold_pin         <= 1'b0;
            frame_pin_n           <= 1'b1;
            card_io_read_pin_n    <= 1'b1;
            card_io_write_pin_n   <= 1'b1;
            we_pin_n              <= 1'b1;
            card_a_enable_low_n   <= 1'b1;
            card_b_enable_low_n   <= 1'b1;
            card_a_enable_high_n  <= 1'b1;
            card_b_enable_high_n  <= 1'b1;
            dma_transfer_ack_pin  <= 1'b0;
        end else if (acc_start) begin
            // First cycle: address, selects and strobes
            addr_pins             <= sel_addr;
            bus_cycle_start_pin_n <= 1'b0;
            area_select_pins_n    <= ~({{(AREAS-1){1'b0}}, 1'b1}
                                       << sel_area);
            read_write_dir_pin    <= ~sel_write;
            addr_hold_pin         <= 1'b1;
            frame_pin_n           <= 1'b0;
            dma_transfer_ack_pin  <= sel_dma_transfer_ack_pin;
            if (sel_card) begin
                // Card space uses its own strobes and enables
                card_io_read_pin_n   <= sel_write;
                card_io_write_pin_n  <= ~sel_write;
                we_pin_n             <= ~sel_write;
                card_a_enable_low_n  <= ~(~sel_area[0] & sel_be[0]);
                card_b_enable_low_n  <= ~(sel_area[0] & sel_be[0]);
                card_a_enable_high_n <= ~(~sel_area[0] & sel_be[1]);
                card_b_enable_high_n <= ~(sel_area[0] & sel_be[1]);
            end else begin
                rd_strobe_pin_n      <= sel_write;
                byte_write_strobes_n <= sel_write ? ~sel_be : 4'hf;
            end
        end else if (acc_end) begin
            // Access over: all strobes back to inactive
            bus_cycle_start_pin_n <= 1'b1;
            area_select_pins_n    <= {AREAS{1'b1}};
            read_write_dir_pin    <= 1'b1;
            byte_write_strobes_n  <= 4'hf;
            rd_strobe_pin_n       <= 1'b1;
            addr_hold_pin         <= 1'b0;
            frame_pin_n           <= 1'b1;
            card_io_read_pin_n    <= 1'b1;
            card_io_write_pin_n   <= 1'b1;
            we_pin_n              <= 1'b1;
            card_a_enable_low_n   <= 1'b1;
            card_b_enable_low_n   <= 1'b1;
            card_a_enable_high_n  <= 1'b1;
            card_b_enable_high_n  <= 1'b1;
            dma_transfer_ack_pin  <= 1'b0;
        end else if (state == ST_ACC) begin
            // Start and hold marks last one cycle only
            bus_cycle_start_pin_n <= 1'b1;
            addr_hold_pin         <= 1'b0;
        end
    end

    // Pin drive enables; floated after reset until settled
    always @(posedge ref_clk) begin
        if (!rstn) begin
            addr_oe <= 1'b0;
            ctrl_oe <= 1'b0;
        end else begin
            addr_oe <= sel_pins_drv;
            ctrl_oe <= sel_pins_drv;
        end
    end

endmodule

// >>> dv/bic_top_monitor.sv
`timescale 1ns/1ps
`include "bic_consts.vh"

module bic_top_monitor #(
    parameter ACC_CYCLES = 2  // Bus cycles per access
) (
    // Clock and reset
    input wire                   ref_clk,
    input wire                   rstn,
    // Register port
    input wire [`BIC_ADDR_W-1:0] reg_addr,
    input wire [31:0]            reg_wdata,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [31:0]            reg_rdata,
    // System state
    input wire                   sw_standby,
    input wire                   bus_release,
    // Access side
    input wire                   acc_req,
    input wire                   acc_dma_transfer_ack_pin,
    input wire                   acc_dma_transfer_ack_pin_drv,
    input wire                   acc_ready,
    input wire                   acc_done,
    // Pins
    input wire                   addr_oe,
    input wire                   bus_cycle_start_pin_n,
    input wire                   ctrl_oe
);
    localparam int ACC = ACC_CYCLES;       // Active cycles per access
    logic       mode_sh;                   // Shadow placement mode
    logic       drive_sh;                  // Shadow standby drive bit
    logic [1:0] cnt_sh;                    // Shadow idle count
    logic       prev_dk;                   // Last access acknowledged
    logic       prev_dv;                   // Last access device drove
    wire        sel  = reg_addr == `BIC_REG_BCC;
    wire        take = acc_req && acc_ready;
    // Take in the done cycle: no idle elapsed, full count applies
    wire        b2b  = take && acc_done && cnt_sh == 2'h3;

    // Shadow of the writable fields
    always @(posedge ref_clk) begin
        if (!rstn) begin
            mode_sh  <= 1'b0;
            drive_sh <= 1'b0;
            cnt_sh   <= 2'h0;
        end else if (reg_wr && sel) begin
            mode_sh  <= reg_wdata[5];
            drive_sh <= reg_wdata[1];
            cnt_sh   <= reg_wdata[7:6];
        end
    end

    // Flags of the last access taken
    always @(posedge ref_clk) begin
        if (!rstn) begin
            prev_dk <= 1'b0;
            prev_dv <= 1'b0;
        end else if (take) begin
            prev_dk <= acc_dma_transfer_ack_pin;
            prev_dv <= acc_dma_transfer_ack_pin && acc_dma_transfer_ack_pin_drv;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Three quiet cycles before the start strobe
    property gap3_p(c);
        c |=> bus_cycle_start_pin_n [*3] ##1 !bus_cycle_start_pin_n;
    endproperty

    AST_RSV_ONE: assert property (
        reg_rd && sel |=> reg_rdata[4] == 1'b1)
        else $error("reserved bit 4 not one");
    AST_RSV_ZERO: assert property (
        reg_rd && sel |=> reg_rdata[3:2] == 2'h0)
        else $error("reserved bits 3:2 not zero");
    AST_MODE_RD: assert property (
        reg_rd && sel |=> reg_rdata[5] == mode_sh
            && reg_rdata[7:6] == cnt_sh && reg_rdata[1] == drive_sh)
        else $error("field readback wrong");
    AST_REL_FLOAT: assert property (
        bus_release |=> !addr_oe && !ctrl_oe)
        else $error("pins driven while bus released");
    AST_SBY_FLOAT: assert property (
        sw_standby && !drive_sh |=> !addr_oe && !ctrl_oe)
        else $error("pins driven in standby");
    AST_SBY_DRIVE: assert property (
        sw_standby && drive_sh && !bus_release |=> addr_oe && ctrl_oe)
        else $error("pins floated in standby");
    AST_HANDOVER_GAP: assert property (gap3_p(
        b2b && !mode_sh && prev_dv && !(acc_dma_transfer_ack_pin && acc_dma_transfer_ack_pin_drv)))
        else $error("no idle on data bus handover");
    AST_ALWAYS_GAP: assert property (
        gap3_p(b2b && mode_sh && prev_dk))
        else $error("no idle after acknowledged access");
    AST_SAME_DRV: assert property (
        take && acc_done && !mode_sh && prev_dv && acc_dma_transfer_ack_pin
            && acc_dma_transfer_ack_pin_drv |=> !bus_cycle_start_pin_n ##ACC acc_done)
        else $error("idle inserted for same driver");

    C_ALWAYS: cover property (b2b && mode_sh && prev_dk);
    C_HANDOVER: cover property (b2b && !mode_sh && prev_dv);
    C_SBY_DRIVE: cover property (sw_standby && drive_sh);
endmodule

bind bic_top bic_top_monitor #(.ACC_CYCLES(ACC_CYCLES)) u_bic_top_monitor (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sw_standby(sw_standby),
    .bus_release(bus_release), .acc_req(acc_req), .acc_dma_transfer_ack_pin(acc_dma_transfer_ack_pin),
    .acc_dma_transfer_ack_pin_drv(acc_dma_transfer_ack_pin_drv), .acc_ready(acc_ready),
    .acc_done(acc_done), .addr_oe(addr_oe),
    .bus_cycle_start_pin_n(bus_cycle_start_pin_n), .ctrl_oe(ctrl_oe));

// >>> dv/bic_ext_dev.sv
`timescale 1ns/1ps

// External device: sees wire levels, pull-up when pins float
module bic_ext_dev (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rstn,
    // Bus pins
    input  wire       ctrl_oe,
    input  wire       bus_cycle_start_pin_n,
    // Observation
    output logic [7:0] n_start
);
    wire  start_lvl = ctrl_oe ? bus_cycle_start_pin_n : 1'b1;
    logic last_lvl;                        // Level seen one edge ago

    // Count each falling start strobe on the wire
    always @(posedge ref_clk) begin
        last_lvl <= start_lvl;
        if (!rstn) begin
            n_start <= 8'h00;
        end else if (last_lvl && !start_lvl) begin
            n_start <= n_start + 8'h01;
        end
    end
endmodule

// >>> dv/test_bic_top.sv
`timescale 1ns/1ps
`include "bic_consts.vh"

module test_bic_top;
    logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic sw_standby = 0, bus_release = 0, acc_req = 0, acc_write = 0;
    logic acc_card = 0, acc_dma_transfer_ack_pin = 0, acc_dma_transfer_ack_pin_drv = 0;
    logic [29:0] acc_addr = 30'h0;
    logic [3:0]  acc_be = 4'h1;
    logic [2:0]  acc_area = 3'h0;
    wire  [31:0] reg_rdata;
    wire  acc_ready, acc_done, addr_oe, ctrl_oe, start_n, ack;
    wire  [7:0]  n_start;
    int   n_mismatch = 0, total_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    bic_top u_bic_top (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sw_standby(sw_standby),
        .bus_release(bus_release), .acc_req(acc_req), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_be(acc_be), .acc_area(acc_area),
        .acc_card(acc_card), .acc_dma_transfer_ack_pin(acc_dma_transfer_ack_pin),
        .acc_dma_transfer_ack_pin_drv(acc_dma_transfer_ack_pin_drv), .acc_ready(acc_ready),
        .acc_done(acc_done), .addr_pins(), .addr_oe(addr_oe),
        .bus_cycle_start_pin_n(start_n), .area_select_pins_n(),
        .read_write_dir_pin(), .byte_write_strobes_n(),
        .rd_strobe_pin_n(), .addr_hold_pin(), .frame_pin_n(),
        .card_io_read_pin_n(), .card_io_write_pin_n(), .we_pin_n(),
        .card_a_enable_low_n(), .card_b_enable_low_n(),
        .card_a_enable_high_n(), .card_b_enable_high_n(),
        .ctrl_oe(ctrl_oe), .dma_transfer_ack_pin(ack));

    bic_ext_dev u_bic_ext_dev (.ref_clk(ref_clk), .rstn(rstn),
        .ctrl_oe(ctrl_oe), .bus_cycle_start_pin_n(start_n),
        .n_start(n_start));

    // Verdict and end of run
    task automatic end_of_test;
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One comparison; unknown counts as mismatch
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Register image; bit 4 written 1, bits 3:2 written 0
    function automatic [31:0] cfg(input [1:0] c, input m, input d);
        cfg = {24'h0, c, m, 1'b1, 2'b00, d, 1'b0};
    endfunction

    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input [7:0] a, input [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata === exp, "register read");
    endtask

    // Pin enables one cycle after the state change
    task automatic sby(input logic s, input logic r, input logic exp);
        @(posedge ref_clk);
        sw_standby <= s; bus_release <= r;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(ctrl_oe === exp && addr_oe === exp, "pin enable");
    endtask

    // One access; next one is presented at the take edge
    task automatic acc(input logic dk, dv, more, nk, nv, input int gap);
        int t;
        int n;
        if (acc_req !== 1'b1) begin
            @(posedge ref_clk);
            acc_req <= 1'b1; acc_dma_transfer_ack_pin <= dk; acc_dma_transfer_ack_pin_drv <= dv;
        end
        t = 0;
        @(negedge ref_clk);
        while (acc_ready !== 1'b1 && t < 50) begin
            t++;
            @(negedge ref_clk);
        end
        if (t >= 50) begin
            n_mismatch++;
            end_of_test();
        end
        @(posedge ref_clk);
        acc_req <= more; acc_dma_transfer_ack_pin <= nk; acc_dma_transfer_ack_pin_drv <= nv;
        acc_addr <= acc_addr + 30'h4; acc_write <= ~acc_write;
        acc_area <= acc_area + 3'h1; acc_card <= ~acc_card;
        acc_be <= {acc_be[2:0], acc_be[3]};
        n = 0;
        @(negedge ref_clk);
        while (start_n === 1'b1 && n < 9) begin
            n++;
            @(negedge ref_clk);
        end
        chk(n == gap, "idle cycles before access");
        if (n >= 9) end_of_test();
        chk(ack === dk, "acknowledge pin with access");
        t = 0;
        while (!more && acc_done !== 1'b1 && t < 20) begin
            t++;
            @(negedge ref_clk);
        end
        chk(more || t < 20, "access completion");
        if (t >= 20) end_of_test();
    endtask

    // Two accesses back to back under one configuration
    task automatic pair(input logic m, input logic [1:0] c,
                        input logic adk, adv, bdk, bdv, input int gap);
        wr(`BIC_REG_BCC, cfg(c, m, 1'b0));
        repeat (4) @(posedge ref_clk);
        acc(adk, adv, 1'b1, bdk, bdv, 0);
        acc(bdk, bdv, 1'b0, 1'b0, 1'b0, gap);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`BIC_REG_BCC, 32'h10);
        wr(`BIC_REG_BCC, cfg(2'h3, 1'b1, 1'b1));
        rd(`BIC_REG_BCC, 32'hf2);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0);
        rd(`BIC_REG_BCC, 32'hf2);
        sby(1'b1, 1'b0, 1'b1);
        sby(1'b1, 1'b1, 1'b0);
        sby(1'b0, 1'b1, 1'b0);
        wr(`BIC_REG_BCC, cfg(2'h3, 1'b1, 1'b0));
        sby(1'b1, 1'b0, 1'b0);
        sby(1'b0, 1'b0, 1'b1);
        pair(1'b0, 2'h3, 1, 1, 1, 1, 0);
        pair(1'b0, 2'h3, 1, 1, 0, 0, 3);
        pair(1'b0, 2'h3, 1, 1, 1, 0, 3);
        pair(1'b0, 2'h3, 1, 0, 0, 0, 0);
        pair(1'b1, 2'h3, 1, 0, 1, 0, 3);
        pair(1'b1, 2'h1, 1, 1, 1, 1, 1);
        pair(1'b1, 2'h3, 0, 0, 0, 0, 0);
        pair(1'b1, 2'h0, 1, 0, 1, 0, 0);
        pair(1'b0, 2'h2, 1, 1, 0, 0, 2);
        chk(n_start === 8'h12, "start strobes seen by device");
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`BIC_REG_BCC, 32'h10);
        end_of_test();
    end
endmodule
